/* drive_control_word_decoder.sv */
// Purpose: Decodes the primary control word of a servo drive
// Assumes: AHB-Lite slave, single word transfers, pd_cycle_i one pulse
// Notes:   Motion profile itself lives outside; this block commands it
`timescale 1ns/1ps
`include "drive_control_defines.svh"

module drive_control_word_decoder (
  input  wire logic        clk_i,             // 200 MHz clock
  input  wire logic        rst_b_i,           // Async reset, active low
  input  wire logic        hsel_i,            // AHB select
  input  wire logic [31:0] haddr_i,           // AHB address
  input  wire logic [1:0]  htrans_i,          // AHB transfer type
  input  wire logic        hwrite_i,          // AHB write
  input  wire logic [2:0]  hsize_i,           // AHB size
  input  wire logic        hready_i,          // AHB bus ready
  input  wire logic [31:0] hwdata_i,          // AHB write data
  output logic      [31:0] hrdata_o,          // AHB read data
  output logic             hreadyout_o,       // AHB slave ready
  output logic             hresp_o,           // AHB response, OKAY
  input  wire logic        pd_cycle_i,        // Process-data cycle strobe
  input  wire logic        error_present_i,   // Drive error pending
  input  wire logic        reference_valid_i, // Referencing done and valid
  input  wire logic        standstill_i,      // Actual speed zero
  input  wire logic        speed_zero_i,      // Commanded speed zero
  input  wire logic        motion_done_i,     // Active order finished
  output logic             power_on_o,        // Power stage energized
  output logic [2:0]       ramp_sel_o,        // Active braking ramp
  output logic             order_start_o,     // New order pulse
  output logic             order_active_o,    // Order in progress
  output logic             order_hold_o,      // Order paused
  output logic             jog_o,             // Jog move running
  output logic [1:0]       motion_func_o,     // Selected motion function
  output logic [31:0]      pos_target_o,      // Position target
  output logic [31:0]      speed_cmd_o,       // Speed command
  output logic [31:0]      gear_num_o,        // Gearing numerator
  output logic [31:0]      gear_den_o,        // Gearing denominator
  output logic             irq_o              // Level interrupt
);

  // ==========================================
  // Registers
  logic [15:0] primary_control_word;
  logic [31:0] setpoint_a;
  logic [31:0] speed_cd;
  logic [1:0]  motion_func;
  logic [1:0]  mapping;
  logic [31:0] default_a;
  logic [31:0] default_speed;
  logic [3:0]  irq_status;
  logic [3:0]  irq_mask;
  logic [15:0] primary_status_word;

  drive_control_pkg::drive_state_t state;
  drive_control_pkg::drive_state_t next_state;

  logic        ack_level;
  logic        order_active;
  logic        order_hold;
  logic        abort_brake;
  logic        jog_active;
  logic        jog_brake;

  // ==========================================
  // AHB-Lite slave
  logic        wr_pend;
  logic        rd_pend;
  logic [7:0]  addr_q;
  logic [31:0] rd_mux;

  wire logic       addr_take = hsel_i & htrans_i[1] & hready_i;
  wire logic       wr_en     = wr_pend;
  wire logic [7:0] wa        = addr_q;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_pend     <= 1'b0;
      rd_pend     <= 1'b0;
      addr_q      <= 8'h00;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      hrdata_o    <= 32'h0000_0000;
    end else begin
      wr_pend <= addr_take & hwrite_i;
      rd_pend <= addr_take & ~hwrite_i;
      if (addr_take) begin
        addr_q <= haddr_i[7:0];
      end
      // One wait state on reads so a write just ahead is seen
      hreadyout_o <= ~(addr_take & ~hwrite_i);
      if (rd_pend) begin
        hrdata_o <= rd_mux;
      end
    end
  end

  always_comb begin
    unique case (addr_q)
      `OFS_CONTROL:     rd_mux = {16'h0000, primary_control_word};
      `OFS_STATUS:      rd_mux = {16'h0000, primary_status_word};
      `OFS_SETPOINT_A:  rd_mux = setpoint_a;
      `OFS_SPEED_CD:    rd_mux = speed_cd;
      `OFS_FUNCTION:    rd_mux = {30'h0000_0000, motion_func};
      `OFS_MAPPING:     rd_mux = {30'h0000_0000, mapping};
      `OFS_DEFAULT_A:   rd_mux = default_a;
      `OFS_DEFAULT_SPD: rd_mux = default_speed;
      `OFS_IRQ_STATUS:  rd_mux = {28'h000_0000, irq_status};
      `OFS_IRQ_MASK:    rd_mux = {28'h000_0000, irq_mask};
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  wire logic wr_ctrl = wr_en & (wa == `OFS_CONTROL);
  wire logic wr_spa  = wr_en & (wa == `OFS_SETPOINT_A);
  wire logic wr_spd  = wr_en & (wa == `OFS_SPEED_CD);
  wire logic wr_fun  = wr_en & (wa == `OFS_FUNCTION);
  wire logic wr_map  = wr_en & (wa == `OFS_MAPPING);
  wire logic wr_dfa  = wr_en & (wa == `OFS_DEFAULT_A);
  wire logic wr_dfs  = wr_en & (wa == `OFS_DEFAULT_SPD);
  wire logic wr_ist  = wr_en & (wa == `OFS_IRQ_STATUS);
  wire logic wr_imk  = wr_en & (wa == `OFS_IRQ_MASK);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      primary_control_word <= `RST_CONTROL;
      setpoint_a           <= `RST_DEFAULT;
      speed_cd             <= `RST_DEFAULT;
      motion_func          <= 2'h0;
      mapping              <= `RST_MAPPING;
      default_a            <= `RST_DEFAULT;
      default_speed        <= `RST_DEFAULT;
      irq_mask             <= `RST_IRQ_MASK;
    end else begin
      if (wr_ctrl) primary_control_word <= hwdata_i[15:0];
      if (wr_spa)  setpoint_a           <= hwdata_i;
      if (wr_spd)  speed_cd             <= hwdata_i;
      if (wr_fun)  motion_func          <= hwdata_i[1:0];
      if (wr_map)  mapping              <= hwdata_i[1:0];
      if (wr_dfa)  default_a            <= hwdata_i;
      if (wr_dfs)  default_speed        <= hwdata_i;
      if (wr_imk)  irq_mask             <= hwdata_i[3:0];
    end
  end

  // ==========================================
  // Control word sampling
  logic [15:0] cw;
  logic [15:0] cw_rise;
  logic [15:0] cw_fall;

  control_word_sampler #(
    .WIDTH     (16),
    .GUIDE_BIT (`CW_GUIDE)
  ) u_sampler (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .tick_i  (pd_cycle_i),
    .word_i  (primary_control_word),
    .word_o  (cw),
    .rise_o  (cw_rise),
    .fall_o  (cw_fall)
  );

  // ==========================================
  // Drive state machine
  wire logic no_coast = cw[`CW_NO_COAST];
  wire logic no_quick = cw[`CW_NO_QUICK];
  wire logic err_ack  = cw_rise[`CW_ACK_ERR] & ~error_present_i;

  always_comb begin
    next_state = state;
    unique case (state)
      drive_control_pkg::ST_FAULT: begin
        if (err_ack) next_state = drive_control_pkg::ST_ON_DISABLED;
      end
      drive_control_pkg::ST_ON_DISABLED: begin
        if (!cw[`CW_ON] && no_coast && no_quick)
          next_state = drive_control_pkg::ST_READY_ON;
      end
      drive_control_pkg::ST_READY_ON: begin
        if (cw[`CW_ON]) next_state = drive_control_pkg::ST_SWITCHED_ON;
      end
      drive_control_pkg::ST_SWITCHED_ON: begin
        if (!cw[`CW_ON]) next_state = drive_control_pkg::ST_READY_ON;
        else if (cw[`CW_ENABLE]) next_state = drive_control_pkg::ST_ENABLED;
      end
      drive_control_pkg::ST_ENABLED: begin
        if (!cw[`CW_ON]) next_state = drive_control_pkg::ST_OFF_RAMP;
        else if (!cw[`CW_ENABLE]) next_state = drive_control_pkg::ST_DIS_RAMP;
      end
      drive_control_pkg::ST_OFF_RAMP: begin
        if (standstill_i) next_state = drive_control_pkg::ST_READY_ON;
      end
      drive_control_pkg::ST_DIS_RAMP: begin
        if (standstill_i) next_state = drive_control_pkg::ST_SWITCHED_ON;
      end
      drive_control_pkg::ST_QUICK_STOP: begin
        if (standstill_i) next_state = drive_control_pkg::ST_ON_DISABLED;
      end
    endcase
    // A pending error and the coast and quick-stop commands override the table above
    if (error_present_i) begin
      next_state = drive_control_pkg::ST_FAULT;
    end else if (state != drive_control_pkg::ST_FAULT) begin
      if (!no_coast) begin
        next_state = drive_control_pkg::ST_ON_DISABLED;
      end else if (!no_quick && state != drive_control_pkg::ST_ON_DISABLED
                   && state != drive_control_pkg::ST_READY_ON) begin
        if (state != drive_control_pkg::ST_QUICK_STOP || !standstill_i)
          next_state = drive_control_pkg::ST_QUICK_STOP;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) state <= drive_control_pkg::ST_ON_DISABLED;
    else          state <= next_state;
  end

  // ==========================================
  // Motion orders and jog
  wire logic enabled  = (state == drive_control_pkg::ST_ENABLED);
  wire logic toggled  = cw_rise[`CW_TOGGLE] | cw_fall[`CW_TOGGLE];
  wire logic accept   = enabled & toggled & cw[`CW_ORDER_OK] & ~jog_active;
  wire logic abort    = order_active & ~cw[`CW_ORDER_OK];
  wire logic no_resume = (motion_func == drive_control_pkg::FUNC_VELOCITY)
                       | (motion_func == drive_control_pkg::FUNC_GEARING);
  wire logic pause_drop = order_active & ~cw[`CW_NO_PAUSE] & no_resume;
  wire logic jog_go   = enabled & cw[`CW_JOG] & speed_zero_i
                      & ~order_active & ~jog_active;
  wire logic jog_end  = jog_brake & standstill_i;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_level    <= 1'b0;
      order_active <= 1'b0;
      order_hold   <= 1'b0;
      abort_brake  <= 1'b0;
      jog_active   <= 1'b0;
      jog_brake    <= 1'b0;
    end else begin
      if (accept) ack_level <= cw[`CW_TOGGLE];
      if (!enabled) begin
        order_active <= 1'b0;
        order_hold   <= 1'b0;
        abort_brake  <= 1'b0;
        jog_active   <= 1'b0;
        jog_brake    <= 1'b0;
      end else begin
        if (accept)
          order_active <= 1'b1;
        else if (abort || pause_drop || (motion_done_i && !order_hold))
          order_active <= 1'b0;
        order_hold  <= (order_active | accept) & ~cw[`CW_NO_PAUSE];
        if (abort) abort_brake <= 1'b1;
        else if (standstill_i) abort_brake <= 1'b0;
        if (jog_go) jog_active <= 1'b1;
        else if (jog_end) jog_active <= 1'b0;
        if (jog_active && !cw[`CW_JOG]) jog_brake <= 1'b1;
        else if (jog_end) jog_brake <= 1'b0;
      end
    end
  end

  // ==========================================
  // Setpoint selection
  wire logic [31:0] val_a   = mapping[`MAP_A] ? setpoint_a : default_a;
  wire logic [31:0] val_spd = mapping[`MAP_SPEED] ? speed_cd : default_speed;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pos_target_o  <= 32'h0000_0000;
      speed_cmd_o   <= 32'h0000_0000;
      gear_num_o    <= 32'h0000_0000;
      gear_den_o    <= 32'h0000_0000;
      motion_func_o <= 2'h0;
    end else if (accept) begin
      motion_func_o <= motion_func;
      unique case (motion_func)
        drive_control_pkg::FUNC_VELOCITY: speed_cmd_o <= val_a;
        drive_control_pkg::FUNC_GEARING: begin
          gear_num_o <= val_a;
          gear_den_o <= val_spd;
        end
        default: begin
          pos_target_o <= val_a;
          speed_cmd_o  <= val_spd;
        end
      endcase
    end
  end

  // ==========================================
  // Ramp and drive outputs
  drive_control_pkg::ramp_sel_t next_ramp;
  always_comb begin
    next_ramp = drive_control_pkg::RAMP_NONE;
    if (state == drive_control_pkg::ST_QUICK_STOP)
      next_ramp = drive_control_pkg::RAMP_QUICK;
    else if (state == drive_control_pkg::ST_OFF_RAMP)
      next_ramp = drive_control_pkg::RAMP_FIRST;
    else if (state == drive_control_pkg::ST_DIS_RAMP)
      next_ramp = drive_control_pkg::RAMP_STOP;
    else if (abort_brake)
      next_ramp = drive_control_pkg::RAMP_MAX;
    else if (order_hold)
      next_ramp = drive_control_pkg::RAMP_PAUSE;
    else if (jog_brake)
      next_ramp = drive_control_pkg::RAMP_JOG;
  end

  // Coasting drops power at once; ramps keep it until standstill
  wire logic next_power = enabled
                        | (state == drive_control_pkg::ST_SWITCHED_ON)
                        | (state == drive_control_pkg::ST_OFF_RAMP)
                        | (state == drive_control_pkg::ST_DIS_RAMP)
                        | (state == drive_control_pkg::ST_QUICK_STOP);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      power_on_o     <= 1'b0;
      ramp_sel_o     <= 3'h0;
      order_start_o  <= 1'b0;
      order_active_o <= 1'b0;
      order_hold_o   <= 1'b0;
      jog_o          <= 1'b0;
    end else begin
      power_on_o     <= next_power & no_coast;
      ramp_sel_o     <= next_ramp;
      order_start_o  <= accept;
      order_active_o <= order_active;
      order_hold_o   <= order_hold;
      jog_o          <= jog_active & ~jog_brake;
    end
  end

  // ==========================================
  // Status word
  always_comb begin
    primary_status_word = 16'h0000;
    primary_status_word[`SW_READY_ON]   = (state != drive_control_pkg::ST_FAULT)
                                        & (state != drive_control_pkg::ST_ON_DISABLED);
    primary_status_word[`SW_READY_OP]   = next_power;
    primary_status_word[`SW_OP_EN]      = enabled;
    primary_status_word[`SW_FAULT]      = (state == drive_control_pkg::ST_FAULT);
    primary_status_word[`SW_NO_COAST]   = no_coast;
    primary_status_word[`SW_NO_QUICK]   = no_quick;
    primary_status_word[`SW_ON_DISABLE] = (state == drive_control_pkg::ST_ON_DISABLED);
    primary_status_word[`SW_GUIDE]      = cw[`CW_GUIDE];
    primary_status_word[`SW_REF_VALID]  = reference_valid_i;
    primary_status_word[`SW_ACK]        = ack_level;
    primary_status_word[`SW_STOPPED]    = standstill_i;
  end

  // ==========================================
  // Interrupts, set wins over write-one-clear
  wire logic [3:0] irq_event = {jog_end,
                                abort,
                                (next_state == drive_control_pkg::ST_FAULT)
                                  & (state != drive_control_pkg::ST_FAULT),
                                accept};
  wire logic [3:0] irq_clr   = wr_ist ? hwdata_i[3:0] : 4'h0;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_status <= 4'h0;
      irq_o      <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_event;
      irq_o      <= |(((irq_status & ~irq_clr) | irq_event) & irq_mask);
    end
  end

endmodule : drive_control_word_decoder

/* drive_control_defines.svh */
// Purpose: Offsets, bit positions and reset values of the control word decoder
// Assumes: 32-bit register words, byte addresses
// Notes:   Definitions only
`ifndef DRIVE_CONTROL_DEFINES_SVH
`define DRIVE_CONTROL_DEFINES_SVH

// ==========================================
// Register byte offsets
`define OFS_CONTROL      8'h00
`define OFS_STATUS       8'h04
`define OFS_SETPOINT_A   8'h08
`define OFS_SPEED_CD     8'h0C
`define OFS_FUNCTION     8'h10
`define OFS_MAPPING      8'h14
`define OFS_DEFAULT_A    8'h18
`define OFS_DEFAULT_SPD  8'h1C
`define OFS_IRQ_STATUS   8'h20
`define OFS_IRQ_MASK     8'h24

// ==========================================
// Control word bits
`define CW_ON            0
`define CW_NO_COAST      1
`define CW_NO_QUICK      2
`define CW_ENABLE        3
`define CW_ORDER_OK      4
`define CW_NO_PAUSE      5
`define CW_TOGGLE        6
`define CW_ACK_ERR       7
`define CW_JOG           8
`define CW_GUIDE         10

// ==========================================
// Status word bits
`define SW_READY_ON      0
`define SW_READY_OP      1
`define SW_OP_EN         2
`define SW_FAULT         3
`define SW_NO_COAST      4
`define SW_NO_QUICK      5
`define SW_ON_DISABLE    6
`define SW_GUIDE         9
`define SW_REF_VALID     11
`define SW_ACK           12
`define SW_STOPPED       13

// ==========================================
// Mapping bits, interrupt bits
`define MAP_A            0
`define MAP_SPEED        1
`define IRQ_ACCEPT       0
`define IRQ_FAULT        1
`define IRQ_ABORT        2
`define IRQ_JOG_DONE     3

// ==========================================
// Reset values
`define RST_CONTROL      16'h0000
`define RST_MAPPING      2'h3
`define RST_DEFAULT      32'h0000_0000
`define RST_IRQ_MASK     4'h0

`endif

/* drive_control_pkg.sv */
// Purpose: Types shared by the control word decoder
// Assumes: None
// Notes:   Constants live in drive_control_defines.svh
package drive_control_pkg;

  typedef enum logic [7:0] {
    ST_ON_DISABLED = 8'h01,
    ST_READY_ON    = 8'h02,
    ST_SWITCHED_ON = 8'h04,
    ST_ENABLED     = 8'h08,
    ST_OFF_RAMP    = 8'h10,
    ST_DIS_RAMP    = 8'h20,
    ST_QUICK_STOP  = 8'h40,
    ST_FAULT       = 8'h80
  } drive_state_t;

  typedef enum logic [2:0] {
    RAMP_NONE  = 3'h0,
    RAMP_FIRST = 3'h1,
    RAMP_QUICK = 3'h2,
    RAMP_STOP  = 3'h3,
    RAMP_MAX   = 3'h4,
    RAMP_PAUSE = 3'h5,
    RAMP_JOG   = 3'h6
  } ramp_sel_t;

  typedef enum logic [1:0] {
    FUNC_POSITION = 2'h0,
    FUNC_VELOCITY = 2'h1,
    FUNC_GEARING  = 2'h2
  } motion_func_t;

endpackage : drive_control_pkg

/* control_word_sampler.sv */
// Purpose: Samples the control word once per cycle and flags bit edges
// Assumes: tick_i is a one-clock pulse per process-data cycle
// Notes:   With the guide bit low only the guide bit itself follows input
`timescale 1ns/1ps
module control_word_sampler #(
  parameter int WIDTH     = 16,
  parameter int GUIDE_BIT = 10
) (
  input  wire logic             clk_i,   // System clock
  input  wire logic             rst_b_i, // Async reset, active low
  input  wire logic             tick_i,  // Cycle strobe
  input  wire logic [WIDTH-1:0] word_i,  // Raw control word
  output logic      [WIDTH-1:0] word_o,  // Sampled control word
  output logic      [WIDTH-1:0] rise_o,  // Rising edge pulses
  output logic      [WIDTH-1:0] fall_o   // Falling edge pulses
);

  wire logic guide = word_i[GUIDE_BIT];

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    wire logic take = tick_i & (guide | (i == GUIDE_BIT));
    wire logic nxt  = take ? word_i[i] : word_o[i];

    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        word_o[i] <= 1'b0;
        rise_o[i] <= 1'b0;
        fall_o[i] <= 1'b0;
      end else begin
        word_o[i] <= nxt;
        rise_o[i] <= nxt & ~word_o[i];
        fall_o[i] <= ~nxt & word_o[i];
      end
    end
  end

endmodule : control_word_sampler

/* drive_control_word_decoder_assertions.sv */
// Purpose: Port-level checks of the control word decoder
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound to every decoder instance
`timescale 1ns/1ps
module drive_control_checker (
  input wire logic       clk_i,         // Clock
  input wire logic       rst_b_i,       // Reset, active low
  input wire logic       hsel_i,        // Select
  input wire logic [1:0] htrans_i,      // Transfer type
  input wire logic       hwrite_i,      // Write
  input wire logic       hready_i,      // Bus ready
  input wire logic       hreadyout_o,   // Slave ready
  input wire logic       hresp_o,       // Response
  input wire logic       pd_cycle_i,    // Cycle strobe
  input wire logic       power_on_o,    // Power stage
  input wire logic [2:0] ramp_sel_o,    // Ramp
  input wire logic       order_start_o, // Order pulse
  input wire logic       jog_o,         // Jog
  input wire logic       irq_o          // Interrupt
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  wire taken = hsel_i & htrans_i[1] & hready_i;
  // ==========================================
  // Bus and command timing
  property p_okay; hresp_o == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("response not OKAY");
  property p_read_wait; taken && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o; endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");
  property p_write_fast; taken && hwrite_i |=> hreadyout_o; endproperty
  a_write_fast: assert property (p_write_fast) else $error("write stalled");
  property p_start_tick; order_start_o |-> $past(pd_cycle_i, 2); endproperty
  a_start_tick: assert property (p_start_tick) else $error("order start off cycle");
  property p_start_pulse; order_start_o |=> !order_start_o; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("order start too long");
  property p_start_power; order_start_o |-> power_on_o; endproperty
  a_start_power: assert property (p_start_power) else $error("order without power");
  property p_jog_power; $rose(jog_o) |-> power_on_o; endproperty
  a_jog_power: assert property (p_jog_power) else $error("jog without power");
  property p_ramp_code; ramp_sel_o <= 3'h6; endproperty
  a_ramp_code: assert property (p_ramp_code) else $error("ramp code invalid");
  c_start: cover property (order_start_o);
  c_jog: cover property ($rose(jog_o));
  c_irq: cover property ($rose(irq_o));
endmodule : drive_control_checker

bind drive_control_word_decoder drive_control_checker u_chk (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .hsel_i(hsel_i), .htrans_i(htrans_i),
  .hwrite_i(hwrite_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o), .pd_cycle_i(pd_cycle_i), .power_on_o(power_on_o),
  .ramp_sel_o(ramp_sel_o), .order_start_o(order_start_o), .jog_o(jog_o), .irq_o(irq_o));

/* fieldbus_cycle_model.sv */
// Purpose: Process-data cycle of the fieldbus master
// Assumes: One strobe every PERIOD clocks
// Notes:   Runs free, as the master's bus cycle does
`timescale 1ns/1ps
module fieldbus_cycle_model #(
  parameter int PERIOD = 8
) (
  input  wire logic clk_i,     // Clock
  input  wire logic rst_b_i,   // Reset, active low
  output logic      pd_cycle_o // Cycle strobe
);
  int count;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count      <= 0;
      pd_cycle_o <= 1'b0;
    end else begin
      count      <= (count == PERIOD - 1) ? 0 : count + 1;
      pd_cycle_o <= (count == PERIOD - 1);
    end
  end
endmodule : fieldbus_cycle_model

/* drive_control_word_decoder_bench.sv */
// Purpose: Self-checking bench for the control word decoder
// Assumes: Status read back over the bus after each step
// Notes:   Guide bit stays set except where freezing is tested
`timescale 1ns/1ps
`include "drive_control_defines.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; $display("Error %s exp %h got %h", n, e, g); end end
module drive_control_word_decoder_bench;
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic        err = 1'b0;
  logic        ref_ok = 1'b0;
  logic        spd0 = 1'b1;
  logic [31:0] hrdata, q, pos, spd, num, den;
  logic        hready, hresp, pd, pwr, start, act, hold, jog, irq;
  logic [2:0]  ramp;
  logic [1:0]  func;
  int          bad_count = 0;
  int          tests_run = 0;
  int          cycles = 0;
  fieldbus_cycle_model #(.PERIOD(8)) cyc (.clk_i(clk_i), .rst_b_i(rst_b_i), .pd_cycle_o(pd));
  drive_control_word_decoder dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .hsel_i(1'b1), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hready), .hwdata_i(hwdata),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .pd_cycle_i(pd), .error_present_i(err),
    .reference_valid_i(ref_ok), .standstill_i(1'b1), .speed_zero_i(spd0), .motion_done_i(1'b0),
    .power_on_o(pwr), .ramp_sel_o(ramp), .order_start_o(start), .order_active_o(act),
    .order_hold_o(hold), .jog_o(jog), .motion_func_o(func), .pos_target_o(pos), .speed_cmd_o(spd),
    .gear_num_o(num), .gear_den_o(den), .irq_o(irq));
  initial forever #2.5 clk_i = ~clk_i;
  // ==========================================
  // Bus tasks
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk_i);
    while (!hready) @(posedge clk_i);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_i);
    while (!hready) @(posedge clk_i);
    q = hrdata;
  endtask : xfer
  task automatic bit_is(input int b, input logic v);
    xfer(`OFS_STATUS, 1'b0, 32'h0000_0000);
    `CHK("status bit", v, q[b])
  endtask : bit_is
  // Thirty clocks, nearly four process-data cycles, cover sample, state and output stages
  task automatic step(input logic [15:0] cw, input int b, input logic v);
    xfer(`OFS_CONTROL, 1'b1, {16'h0000, cw});
    repeat (30) @(posedge clk_i);
    bit_is(b, v);
  endtask : step
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end
  // ==========================================
  // Tests
  initial begin
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'b1;
    xfer(`OFS_MAPPING, 1'b0, 32'h0000_0000);
    `CHK("mapping", 32'h0000_0003, q)
    xfer(8'h30, 1'b1, 32'hFFFF_FFFF);
    xfer(8'h30, 1'b0, 32'h0000_0000);
    `CHK("unmapped", 32'h0000_0000, q)
    bit_is(`SW_ON_DISABLE, 1'b1);
    $display("test reset done");
    ref_ok <= 1'b1;
    step(16'h0406, `SW_READY_ON, 1'b1);
    bit_is(`SW_REF_VALID, 1'b1);
    step(16'h0407, `SW_READY_OP, 1'b1);
    step(16'h040F, `SW_OP_EN, 1'b1);
    xfer(`OFS_FUNCTION, 1'b1, 32'h0000_0002);
    xfer(`OFS_SETPOINT_A, 1'b1, 32'h0000_0005);
    xfer(`OFS_SPEED_CD, 1'b1, 32'h0000_0007);
    xfer(`OFS_IRQ_MASK, 1'b1, 32'h0000_0001);
    step(16'h047F, `SW_ACK, 1'b1);
    `CHK("numerator", 32'h0000_0005, num)
    `CHK("denominator", 32'h0000_0007, den)
    `CHK("function", 2'h2, func)
    `CHK("irq", 1'b1, irq)
    xfer(`OFS_IRQ_STATUS, 1'b1, 32'h0000_000F);
    repeat (2) @(posedge clk_i);
    `CHK("irq", 1'b0, irq)
    xfer(`OFS_FUNCTION, 1'b1, 32'h0000_0001);
    step(16'h043F, `SW_ACK, 1'b0);
    `CHK("speed", 32'h0000_0005, spd)
    xfer(`OFS_MAPPING, 1'b1, 32'h0000_0000);
    xfer(`OFS_DEFAULT_A, 1'b1, 32'h0000_0009);
    xfer(`OFS_FUNCTION, 1'b1, 32'h0000_0000);
    step(16'h047F, `SW_ACK, 1'b1);
    `CHK("position", 32'h0000_0009, pos)
    step(16'h045F, `SW_OP_EN, 1'b1);
    `CHK("hold", 1'b1, hold)
    `CHK("ramp", 3'h5, ramp)
    step(16'h047F, `SW_OP_EN, 1'b1);
    `CHK("resumed", 2'b10, {act, hold})
    step(16'h046F, `SW_OP_EN, 1'b1);
    `CHK("discarded", 1'b0, act)
    $display("test order done");
    step(16'h0000, `SW_OP_EN, 1'b1);
    step(16'h050F, `SW_OP_EN, 1'b1);
    `CHK("jog", 1'b1, jog)
    step(16'h040F, `SW_OP_EN, 1'b1);
    `CHK("jog", 1'b0, jog)
    $display("test jog done");
    step(16'h0407, `SW_OP_EN, 1'b0);
    bit_is(`SW_READY_OP, 1'b1);
    step(16'h0406, `SW_READY_ON, 1'b1);
    `CHK("power", 1'b0, pwr)
    step(16'h040F, `SW_OP_EN, 1'b1);
    step(16'h040B, `SW_ON_DISABLE, 1'b1);
    `CHK("power", 1'b0, pwr)
    step(16'h0406, `SW_READY_ON, 1'b1);
    step(16'h0407, `SW_READY_OP, 1'b1);
    step(16'h0405, `SW_ON_DISABLE, 1'b1);
    `CHK("power", 1'b0, pwr)
    err <= 1'b1;
    step(16'h0406, `SW_FAULT, 1'b1);
    err <= 1'b0;
    step(16'h0480, `SW_FAULT, 1'b0);
    bit_is(`SW_ON_DISABLE, 1'b1);
    $display("test shutdown done");
    report_and_stop();
  end
endmodule : drive_control_word_decoder_bench
